/* hw/vcrr_pkg.sv */
package vcrr_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses in configuration space)
    // ------------------------------------------------------------
    localparam logic [11:0] VCRR_OFS_CAP     = 12'h158; // channel resource capability
    localparam logic [11:0] VCRR_OFS_CTRL    = 12'h15C; // channel resource control
    localparam logic [11:0] VCRR_OFS_STAT    = 12'h160; // channel resource status

    // ------------------------------------------------------------
    // device-specific group bounds
    // ------------------------------------------------------------
    localparam logic [11:0] VCRR_ERR_LO      = 12'h1C8; // error check and debug group
    localparam logic [11:0] VCRR_ERR_HI      = 12'h1FC;
    localparam logic [11:0] VCRR_PHY_LO      = 12'h200; // physical layer group
    localparam logic [11:0] VCRR_PHY_HI      = 12'h2C4;
    localparam logic [11:0] VCRR_CAM_LO      = 12'h2C8; // routing cam group
    localparam logic [11:0] VCRR_CAM_HI      = 12'h6BC;
    localparam logic [11:0] VCRR_BAR_LO      = 12'h6C0; // base address shadow group
    localparam logic [11:0] VCRR_BAR_HI      = 12'h73C;
    localparam logic [11:0] VCRR_RSV_LO      = 12'h740; // reserved hole
    localparam logic [11:0] VCRR_RSV_HI      = 12'h9EC;
    localparam logic [11:0] VCRR_ICH_LO      = 12'h9F0; // ingress credit handler group
    localparam logic [11:0] VCRR_ICH_HI      = 12'hB7C;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          VCRR_MAP_LSB     = 1;       // writable map bits 7:1
    localparam int          VCRR_MAP_MSB     = 7;
    localparam logic [7:0]  VCRR_MAP_RST     = 8'hFF;   // every class mapped at reset
    localparam int          VCRR_EN_BIT      = 31;      // channel enable
    localparam int          VCRR_PEND_BIT    = 17;      // negotiation pending
    localparam logic [31:0] VCRR_CAP_VALUE   = 32'h0000_0000;

    // ------------------------------------------------------------
    // device-specific group select
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VCRR_GRP_NONE = 3'h0,
        VCRR_GRP_ERR  = 3'h1,
        VCRR_GRP_PHY  = 3'h3,
        VCRR_GRP_CAM  = 3'h2,
        VCRR_GRP_BAR  = 3'h6,
        VCRR_GRP_RSV  = 3'h7,
        VCRR_GRP_ICH  = 3'h5
    } vcrr_grp_t;

    // configuration request carried as one bundle
    typedef struct packed {
        logic        rd;      // read strobe
        logic        wr;      // write strobe
        logic        mem;     // memory-mapped path
        logic        ind;     // indirect configuration path
        logic [11:0] addr;    // byte address
        logic [3:0]  be;      // byte enables
        logic [31:0] wdata;   // write data
    } vcrr_req_t;

endpackage : vcrr_pkg

/* hw/vcrr_regs.sv */
`timescale 1ns/1ps

// Behaviour
// - capability register always reads zero
// - map bit 0 reads fixed one
// - map bits 7:1 writable, reset set
// - arbitration load/select fields read zero
// - channel identifier field reads zero
// - channel enable bit always reads one
// - arbitration table status reads zero
// - pending set from reset until negotiation done
// - decode error/debug and physical layer groups
// - decode routing cam and shadow groups
// - reserved hole, then ingress credit group
// - reverse bridge: memory and indirect access
// - control register at offset 15Ch
module vcrr_regs
    import vcrr_pkg::*;
(
    input  wire logic        sys_clk,          // core clock, 25 MHz
    input  wire logic        rst,              // async, active high
    input  wire vcrr_req_t   req,              // configuration request
    input  wire logic        reverse_bridge,   // reverse transparent bridge mode
    input  wire logic        link_vc_init_done,// link channel init finished
    output logic [31:0]      rdata,            // read data
    output logic             ack,              // one-cycle answer pulse
    output logic [7:0]       class_to_channel_map, // current class map
    output logic             ds_sel,           // device-specific access strobe
    output vcrr_grp_t        ds_group          // selected device-specific group
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // group lookup, used for reads and writes alike
    // ranges are inclusive; an address outside every group decodes as none
    function automatic vcrr_grp_t grp_of(input logic [11:0] a);
        if (a >= VCRR_ERR_LO && a <= VCRR_ERR_HI) begin
            grp_of = VCRR_GRP_ERR;
        end else if (a >= VCRR_PHY_LO && a <= VCRR_PHY_HI) begin
            grp_of = VCRR_GRP_PHY;
        end else if (a >= VCRR_CAM_LO && a <= VCRR_CAM_HI) begin
            grp_of = VCRR_GRP_CAM;
        end else if (a >= VCRR_BAR_LO && a <= VCRR_BAR_HI) begin
            grp_of = VCRR_GRP_BAR;
        end else if (a >= VCRR_RSV_LO && a <= VCRR_RSV_HI) begin
            grp_of = VCRR_GRP_RSV;
        end else if (a >= VCRR_ICH_LO && a <= VCRR_ICH_HI) begin
            grp_of = VCRR_GRP_ICH;
        end else begin
            grp_of = VCRR_GRP_NONE;
        end
    endfunction : grp_of

    // request-side decode, combinational from the bundle; map_q and pending are registered
    logic              access;      // any strobe this cycle
    logic              path_ok;     // access path permitted
    logic [31:0]       next_rdata;  // read mux result
    logic [7:0]        map_q;       // writable class map bits
    logic              pending;     // negotiation pending state
    vcrr_grp_t         grp_now;     // decoded group

    assign access  = req.rd | req.wr;
    assign grp_now = grp_of(req.addr);
    // in reverse mode either path reaches the device-specific space,
    // otherwise only plain configuration (neither alternate path flagged)
    assign path_ok = reverse_bridge ? (req.mem | req.ind)
                                    : ~(req.mem | req.ind);

    // ------------------------------------------------------------
    // class map register
    // ------------------------------------------------------------
    // only bits 7:1 take writes; bit 0 is forced one on read
    // be[0] alone gates the write because the whole map sits in byte 0
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            map_q <= VCRR_MAP_RST;
        end else if (req.wr && req.be[0] && req.addr == VCRR_OFS_CTRL) begin
            map_q[VCRR_MAP_MSB:VCRR_MAP_LSB] <= req.wdata[VCRR_MAP_MSB:VCRR_MAP_LSB];
        end
    end

    // ------------------------------------------------------------
    // negotiation pending flag
    // ------------------------------------------------------------
    // set at reset, falls once the link reports init done; a later
    // loss of init is not re-reported, the link retrains via reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b1;
        end else if (link_vc_init_done) begin
            pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped addresses fall through to zero
    // select is combinational; rdata registers it one edge later, so a
    // requester sees every read with the same fixed one-cycle latency
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.addr == VCRR_OFS_CAP) begin
            next_rdata = VCRR_CAP_VALUE;
        end else if (req.addr == VCRR_OFS_CTRL) begin
            // load/select and id fields stay zero
            next_rdata[VCRR_MAP_MSB:VCRR_MAP_LSB] = map_q[VCRR_MAP_MSB:VCRR_MAP_LSB];
            next_rdata[0]           = 1'b1;
            next_rdata[VCRR_EN_BIT] = 1'b1;
        end else if (req.addr == VCRR_OFS_STAT) begin
            next_rdata[VCRR_PEND_BIT] = pending;
        end
        // bit 16 of control and status stays zero
        next_rdata[16] = 1'b0;
        next_rdata[16] = next_rdata[16] & 1'b0;
        next_rdata[26:24] = 3'h0;
    end

    // ------------------------------------------------------------
    // answer and outputs
    // ------------------------------------------------------------
    // writes answer with zero data so a stale read word never lingers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
            ack   <= 1'b0;
        end else begin
            ack   <= access;
            rdata <= req.rd ? next_rdata : 32'h0000_0000;
        end
    end

    // mirror of map with bit 0 held one, for the routing logic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            class_to_channel_map <= VCRR_MAP_RST;
        end else begin
            class_to_channel_map <= {map_q[VCRR_MAP_MSB:VCRR_MAP_LSB], 1'b1};
        end
    end

    // group strobe to the device-specific blocks; reserved hole gets none
    // ds_group still shows the code when the path is refused, so the
    // far blocks can log the attempt without acting on it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ds_sel   <= 1'b0;
            ds_group <= VCRR_GRP_NONE;
        end else begin
            ds_sel   <= access && path_ok && grp_now != VCRR_GRP_NONE
                        && grp_now != VCRR_GRP_RSV;
            ds_group <= access ? grp_now : VCRR_GRP_NONE;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // all checks run on the core clock and sleep through reset
    // read checks look one edge after the strobe, while rdata stands
    sequence s_ctrl_read;
        req.rd && req.addr == VCRR_OFS_CTRL;
    endsequence
    sequence s_stat_read;
        req.rd && req.addr == VCRR_OFS_STAT;
    endsequence
    sequence s_ctrl_write;
        req.wr && req.be[0] && req.addr == VCRR_OFS_CTRL;
    endsequence

    a_cap_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd && req.addr == VCRR_OFS_CAP |=> rdata == 32'h0000_0000)
        else $error("capability read not zero");
    a_map_bit_zero: assert property (@(posedge sys_clk) disable iff (rst)
        s_ctrl_read |=> rdata[0])
        else $error("class zero not mapped");
    a_map_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
        req.wr && req.be[0] && req.addr == VCRR_OFS_CTRL
        |=> ##1 class_to_channel_map[7:1] == $past(req.wdata[7:1], 2))
        else $error("map write lost");
    a_ctrl_ro_zero: assert property (@(posedge sys_clk) disable iff (rst)
        s_ctrl_read |=> rdata[19:16] == 4'h0 && rdata[26:24] == 3'h0)
        else $error("control read-only field nonzero");
    a_enable_one: assert property (@(posedge sys_clk) disable iff (rst)
        s_ctrl_read |=> rdata[31] && rdata[30:27] == 4'h0 && rdata[15:8] == 8'h00)
        else $error("enable not one or reserved set");
    a_pending_state: assert property (@(posedge sys_clk) disable iff (rst)
        s_stat_read |=> rdata[VCRR_PEND_BIT] == $past(pending) && rdata[16] == 1'b0)
        else $error("pending flag wrong");
    a_pending_stays: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(pending) |=> !pending)
        else $error("pending flag came back");
    a_hole_no_sel: assert property (@(posedge sys_clk) disable iff (rst)
        access && grp_now == VCRR_GRP_RSV |=> !ds_sel)
        else $error("reserved hole selected");
    a_reverse_paths: assert property (@(posedge sys_clk) disable iff (rst)
        access && reverse_bridge && (req.mem || req.ind) && grp_now == VCRR_GRP_ERR
        |=> ds_sel && ds_group == VCRR_GRP_ERR)
        else $error("reverse mode access not routed");

    // field, pending, path and write-side checks
    // a write that misses the map must leave it untouched
    a_id_zero: assert property (@(posedge sys_clk) disable iff (rst)
        s_ctrl_read |=> rdata[26:24] == 3'h0 && rdata[23:20] == 4'h0)
        else $error("channel identifier or reserved nonzero");
    a_stat_fields: assert property (@(posedge sys_clk) disable iff (rst)
        s_stat_read |=> rdata[16] == 1'b0 && rdata[15:0] == 16'h0000 && rdata[31:18] == 14'h0000)
        else $error("status read-only field nonzero");
    a_pending_clears: assert property (@(posedge sys_clk) disable iff (rst)
        link_vc_init_done |=> !pending)
        else $error("pending flag not cleared");
    a_plain_no_sel: assert property (@(posedge sys_clk) disable iff (rst)
        access && !reverse_bridge && (req.mem || req.ind) |=> !ds_sel)
        else $error("alternate path selected outside reverse mode");
    a_map_bit_kept: assert property (@(posedge sys_clk) disable iff (rst)
        s_ctrl_write ##0 !req.wdata[0] |=> ##1 class_to_channel_map[0])
        else $error("class zero unmapped by write");
    a_map_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !(req.wr && req.be[0] && req.addr == VCRR_OFS_CTRL) |=> $stable(map_q))
        else $error("map changed without a write");
    a_write_rdata_zero: assert property (@(posedge sys_clk) disable iff (rst)
        req.wr |=> rdata == 32'h0000_0000)
        else $error("write answered with data");

endmodule : vcrr_regs

/* test/vcrr_cfg_requester.sv */
`timescale 1ns/1ps

module vcrr_cfg_requester
    import vcrr_pkg::*;
(
    input  wire logic        sys_clk, // core clock
    input  wire logic        ack,     // answer pulse
    input  wire logic [31:0] rdata,   // read data
    output vcrr_req_t        req      // request bundle
);
    initial req = '0;

    // ------------------------------------------------------------
    // one access: one-cycle strobe, answer taken mid-cycle after the taking edge
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [1:0] path, input logic [11:0] addr,
                        input logic [31:0] wdata, output logic [31:0] data, output logic ok);
        @(posedge sys_clk);
        // callers write only the channel registers, never device-specific space
        req <= '{rd: !wr, wr: wr, mem: path[1], ind: path[0], addr: addr, be: 4'hF,
                 wdata: wdata};
        @(posedge sys_clk);
        // released address and data lines show the inverse so a stale value cannot pass
        req <= '{rd: 1'b0, wr: 1'b0, mem: 1'b0, ind: 1'b0, addr: ~addr, be: 4'h0,
                 wdata: ~wdata};
        // answer stands from this edge to the next; take it mid-cycle
        @(negedge sys_clk);
        ok = (ack === 1'b1);
        data = rdata;
    endtask : xfer
endmodule : vcrr_cfg_requester

/* test/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import vcrr_pkg::*;
    logic        sys_clk, rst, reverse_bridge, link_vc_init_done, ack, ds_sel, ok, s;
    vcrr_req_t   req;
    logic [31:0] rdata, d;
    logic [7:0]  class_to_channel_map;
    vcrr_grp_t   ds_group, g;
    int          fails = 0, check_count = 0, cycles = 0;
    // address table across every group edge, with the expected group code
    logic [11:0] atab[14] = '{12'h1C8, 12'h1FC, 12'h200, 12'h2C4, 12'h2C8, 12'h6BC, 12'h6C0,
                              12'h73C, 12'h740, 12'h9EC, 12'h9F0, 12'hB7C, 12'hB80, 12'h15C};
    vcrr_grp_t   gtab[14] = '{VCRR_GRP_ERR, VCRR_GRP_ERR, VCRR_GRP_PHY, VCRR_GRP_PHY,
                              VCRR_GRP_CAM, VCRR_GRP_CAM, VCRR_GRP_BAR, VCRR_GRP_BAR,
                              VCRR_GRP_RSV, VCRR_GRP_RSV, VCRR_GRP_ICH, VCRR_GRP_ICH,
                              VCRR_GRP_NONE, VCRR_GRP_NONE};

    vcrr_regs vcrr_regs_inst (.sys_clk(sys_clk), .rst(rst), .req(req),
        .reverse_bridge(reverse_bridge), .link_vc_init_done(link_vc_init_done), .rdata(rdata),
        .ack(ack), .class_to_channel_map(class_to_channel_map), .ds_sel(ds_sel),
        .ds_group(ds_group));
    vcrr_cfg_requester vcrr_cfg_requester_inst (.sys_clk(sys_clk), .ack(ack), .rdata(rdata),
        .req(req));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // whole run is under a hundred cycles; 3000 means a hang
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic cmp_word(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_grp(string name, vcrr_grp_t exp, vcrr_grp_t got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_grp
    // access plus answer-pulse check; group outputs captured with the answer
    task automatic acc(logic wr, logic [1:0] p, logic [11:0] a, logic [31:0] w);
        vcrr_cfg_requester_inst.xfer(wr, p, a, w, d, ok);
        s = ds_sel;
        g = ds_group;
        cmp_word("ack", 32'h1, {31'h0, ok});
    endtask : acc
    task automatic rd_chk(string name, logic [11:0] a, logic [31:0] exp);
        acc(1'b0, 2'b00, a, 32'h0);
        cmp_word(name, exp, d);
    endtask : rd_chk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values;
        rd_chk("capability", VCRR_OFS_CAP, 32'h0000_0000);
        rd_chk("control", VCRR_OFS_CTRL, 32'h8000_00FF);
        rd_chk("status", VCRR_OFS_STAT, 32'h0002_0000);
    endtask : test_reset_values
    task automatic test_map_write;
        acc(1'b1, 2'b00, VCRR_OFS_CTRL, 32'hFFFF_FFFF);
        rd_chk("control", VCRR_OFS_CTRL, 32'h8000_00FF);
        acc(1'b1, 2'b00, VCRR_OFS_CTRL, 32'h0000_00AA);
        // the routing copy lags the write by one more edge
        @(negedge sys_clk);
        cmp_word("map", 32'h0000_00AB, {24'h0, class_to_channel_map});
        rd_chk("control", VCRR_OFS_CTRL, 32'h8000_00AB);
        acc(1'b1, 2'b00, VCRR_OFS_CAP, 32'hFFFF_FFFF);
        rd_chk("capability", VCRR_OFS_CAP, 32'h0000_0000);
    endtask : test_map_write
    task automatic test_pending;
        @(posedge sys_clk) link_vc_init_done <= 1'b1;
        @(posedge sys_clk) link_vc_init_done <= 1'b0;
        rd_chk("status", VCRR_OFS_STAT, 32'h0000_0000);
        rd_chk("status", VCRR_OFS_STAT, 32'h0000_0000);
    endtask : test_pending
    // mid-run reset must restore the map and re-arm the pending flag
    task automatic test_rereset;
        @(posedge sys_clk) rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        cmp_word("map", 32'h0000_00FF, {24'h0, class_to_channel_map});
        rd_chk("status", VCRR_OFS_STAT, 32'h0002_0000);
        rd_chk("control", VCRR_OFS_CTRL, 32'h8000_00FF);
    endtask : test_rereset
    task automatic test_decode;
        for (int i = 0; i < 14; i++) begin
            acc(1'b0, 2'b00, atab[i], 32'h0);
            cmp_grp("group", gtab[i], g);
            cmp_word("sel", {31'h0, gtab[i] != VCRR_GRP_NONE && gtab[i] != VCRR_GRP_RSV},
                     {31'h0, s});
        end
        acc(1'b0, 2'b10, VCRR_ERR_LO, 32'h0);
        cmp_word("sel", 32'h0, {31'h0, s});
        @(posedge sys_clk) reverse_bridge <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            acc(1'b0, p[1:0], VCRR_ICH_HI, 32'h0);
            cmp_word("sel", {31'h0, p != 0}, {31'h0, s});
            cmp_grp("group", VCRR_GRP_ICH, g);
        end
        acc(1'b0, 2'b11, VCRR_ERR_LO, 32'h0);
        cmp_word("sel", 32'h1, {31'h0, s});
        cmp_grp("group", VCRR_GRP_ERR, g);
    endtask : test_decode

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    initial begin
        rst = 1'b1;
        reverse_bridge = 1'b0;
        link_vc_init_done = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset_values();
        test_map_write();
        test_pending();
        test_rereset();
        test_decode();
        end_of_test();
    end
endmodule : tb_top
